/* File: pkg/etp_pkg.sv */
// Constants, types and register map of the event timer
// How it works
// - Single-shot: output low while counter stopped
// - Accepted event clears counter, output high
// - At compare stop; hold one tick, ignore events
// - Synchronous output rises two cycles after event
// - Single-shot starts counting at enable, no event
// - Asynchronous output rises at once; count later
// - PWM counts zero to low byte, clears at high
// - PWM period low+1, high cycles equal high byte, none if low byte is zero
// - Immediate-select bit picks synchronous or immediate output
// - Single-shot output high on start, low on stop
// - Other modes drive initial output level
// - Filter passes level when four samples agree
// - Filter runs on undivided clock, four cycles
// - Companion clock select uses companion tick
// - Restart counter when companion timer restarts
// - Each flag set emits one-cycle event strobe
// - One event input, action per edge select
// - Immediate mode detects edges without waiting
// - Interrupt request while flag and enable set
// - Halt in deep sleep; standby needs bit
// - Read-only running status bit
// - Three-bit mode field, 6 single, 7 PWM
// - Clock select 0 direct, 1 half, 2 companion
package etp_pkg;

    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;

    // Register indexes; byte address is four times the index
    localparam logic [3:0] IDX_CTRL_MAIN = 4'h0;
    localparam logic [3:0] IDX_CTRL_MODE = 4'h1;
    localparam logic [3:0] IDX_EV_CTRL   = 4'h4;
    localparam logic [3:0] IDX_INT_EN    = 4'h5;
    localparam logic [3:0] IDX_INT_FLAG  = 4'h6;
    localparam logic [3:0] IDX_STATUS    = 4'h7;
    localparam logic [3:0] IDX_DEBUG     = 4'h8;
    localparam logic [3:0] IDX_LATCH     = 4'h9;
    localparam logic [3:0] IDX_COUNTER   = 4'ha;
    localparam logic [3:0] IDX_COMPARE   = 4'hc;

    // Field positions
    localparam int CM_ENABLE   = 0;
    localparam int CM_CLOCK_SOURCE_SELECT   = 1;
    localparam int CM_RESTART  = 4;
    localparam int CM_STANDBY  = 6;
    localparam int MO_MODE     = 0;
    localparam int MO_OUT_EN   = 4;
    localparam int MO_INIT     = 5;
    localparam int MO_IMMED    = 6;
    localparam int EV_IN_EN    = 0;
    localparam int EV_EDGE     = 4;
    localparam int EV_FILTER   = 6;
    localparam int FLAG_BIT    = 0;
    localparam int RUN_BIT     = 0;
    localparam int HALT_BIT    = 0;

    // Implemented bits of each control byte
    localparam logic [7:0] MASK_CTRL_MAIN = 8'h57;
    localparam logic [7:0] MASK_CTRL_MODE = 8'h77;
    localparam logic [7:0] MASK_EV_CTRL   = 8'h51;
    localparam logic [7:0] MASK_ONE_BIT   = 8'h01;

    // Reset values
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

    // Timing counts in system clock cycles
    localparam int START_DELAY  = 2;
    localparam int FILTER_DEPTH = 4;

    typedef enum logic [2:0] {
        MODE_PERIODIC = 3'b000,
        MODE_TIMEOUT  = 3'b001,
        MODE_CAP_EVT  = 3'b010,
        MODE_CAP_FREQ = 3'b011,
        MODE_CAP_PW   = 3'b100,
        MODE_CAP_FPW  = 3'b101,
        MODE_SINGLE   = 3'b110,
        MODE_PWM      = 3'b111
    } etp_mode_type;

    typedef enum logic [1:0] {
        CLK_PERIPH    = 2'b00,
        CLK_HALF      = 2'b01,
        CLK_COMPANION = 2'b10,
        CLK_RESERVED  = 2'b11
    } etp_clock_source_select_type;

    typedef enum logic [1:0] {
        SS_IDLE  = 2'b00,
        SS_DELAY = 2'b01,
        SS_RUN   = 2'b10,
        SS_HOLD  = 2'b11
    } etp_shot_type;

    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [3:0]        byteenable;
        logic [DATA_W-1:0] writedata;
    } etp_avs_req_type;

endpackage

/* File: hdl/etp_event_timer.sv */
// Event timer with single-shot, PWM and periodic counting
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/10ps
module etp_event_timer (
    input  wire logic                     REF_CLK,
    input  wire logic                     RESET_N,
    input  wire etp_pkg::etp_avs_req_type AVS_REQ,
    output logic [etp_pkg::DATA_W-1:0]    AVS_READDATA,
    output logic                          AVS_WAITREQUEST,
    input  wire logic                     EVENT_IN,
    input  wire logic                     COMPANION_TICK,
    input  wire logic                     COMPANION_RESTART,
    input  wire logic                     SLEEP_STANDBY,
    input  wire logic                     SLEEP_DEEP,
    input  wire logic                     DEBUG_HALT,
    output logic                          WAVEFORM_PIN,
    output logic                          EVENT_OUT,
    output logic                          IRQ
);
    import etp_pkg::*;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [7:0]        main_r;
    logic [7:0]        mode_r;
    logic [7:0]        evc_r;
    logic              ie_r;
    logic              flag_r;
    logic              halt_ovr_r;
    logic [7:0]        latch_r;
    logic [15:0]       cnt_r;
    logic [15:0]       cmp_r;
    logic              ack_r;
    logic [DATA_W-1:0] rdata_r;

    wire        req_act  = AVS_REQ.read | AVS_REQ.write;
    wire [3:0]  idx      = AVS_REQ.address[ADDR_W-1:2];
    wire [3:0]  be       = AVS_REQ.byteenable;
    wire [15:0] wd       = AVS_REQ.writedata[15:0];
    wire        wr_do    = AVS_REQ.write & ack_r;
    wire        rd_load  = AVS_REQ.read & ~ack_r;
    wire        wr_lane0 = wr_do & be[0];

    assign AVS_WAITREQUEST = req_act & ~ack_r;
    assign AVS_READDATA    = rdata_r;

    // Split accesses to the 16-bit words pair through the latch
    wire lo_only = be[0] & ~be[1];
    wire hi_only = be[1] & ~be[0];
    wire both_hl = be[0] & be[1];

    function automatic logic [15:0] word_wr(input logic [15:0] data,
                                            input logic [7:0]  lat);
        word_wr = both_hl ? data : {data[15:8], lat};
    endfunction

    wire cnt_wr   = wr_do & (idx == IDX_COUNTER) & (both_hl | hi_only);
    wire cmp_wr   = wr_do & (idx == IDX_COMPARE) & (both_hl | hi_only);
    wire word_sel = (idx == IDX_COUNTER) | (idx == IDX_COMPARE);
    wire [15:0] word_rd = (idx == IDX_COUNTER) ? cnt_r : cmp_r;

    // ------------------------------------------------------------
    // Decoded controls
    // ------------------------------------------------------------
    etp_mode_type   mode;
    etp_clock_source_select_type clock_source_select;
    etp_shot_type   state_r;
    etp_shot_type   state_nxt;

    assign mode   = etp_mode_type'(mode_r[MO_MODE +: 3]);
    assign clock_source_select = etp_clock_source_select_type'(main_r[CM_CLOCK_SOURCE_SELECT +: 2]);

    wire enable     = main_r[CM_ENABLE];
    wire restart_en = main_r[CM_RESTART];
    wire standby_op = main_r[CM_STANDBY];
    wire out_en     = mode_r[MO_OUT_EN];
    wire init_lvl   = mode_r[MO_INIT];
    wire immed_sel  = mode_r[MO_IMMED];
    wire ev_in_en   = evc_r[EV_IN_EN];
    wire edge_sel   = evc_r[EV_EDGE];
    wire filter_en  = evc_r[EV_FILTER];
    wire is_single  = (mode == MODE_SINGLE);
    wire is_pwm     = (mode == MODE_PWM);

    // Sleep and debug halt freeze the count and event actions
    wire halted = SLEEP_DEEP | (SLEEP_STANDBY & ~standby_op)
                | (DEBUG_HALT & ~halt_ovr_r);
    wire active = enable & ~halted;

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    logic div_r;
    logic base_tick;

    always_comb begin
        case (clock_source_select)
            CLK_PERIPH:    base_tick = 1'b1;
            CLK_HALF:      base_tick = div_r;
            CLK_COMPANION: base_tick = COMPANION_TICK;
            default:       base_tick = 1'b0;
        endcase
    end

    wire tick = active & base_tick;

    // ------------------------------------------------------------
    // Event input filter and edge detector
    // ------------------------------------------------------------
    logic [FILTER_DEPTH-1:0] samp_r;
    logic                    filt_r;
    logic                    prev_lvl_r;

    // Samples on every system clock, not on the prescaled tick
    wire samp_hi = &samp_r;
    wire samp_lo = ~|samp_r;
    wire filt_lvl = samp_hi | (filt_r & ~samp_lo);
    wire lvl     = filter_en ? filt_lvl : EVENT_IN;
    wire rise    = lvl & ~prev_lvl_r;
    wire fall    = ~lvl & prev_lvl_r;
    wire trig    = edge_sel ? (rise | fall) : rise;

    // Only idle single-shot takes an event; hold and run ignore it
    wire hit = active & ev_in_en & is_single & trig
             & (state_r == SS_IDLE);

    // ------------------------------------------------------------
    // Counter and single-shot sequencer
    // ------------------------------------------------------------
    logic        en_prev_r;
    logic [15:0] cnt_nxt;
    logic        set_flag;

    wire enable_rise = enable & ~en_prev_r;
    wire [7:0] cmp_lo = cmp_r[7:0];
    wire [7:0] cmp_hi = cmp_r[15:8];

    always_comb begin
        cnt_nxt   = cnt_r;
        state_nxt = state_r;
        set_flag  = 1'b0;
        case (mode)
            MODE_SINGLE: begin
                case (state_r)
                    SS_IDLE: begin
                        if (hit) begin
                            state_nxt = SS_DELAY;
                            cnt_nxt   = RST_WORD;
                        end
                    end
                    SS_DELAY: begin
                        state_nxt = SS_RUN;
                    end
                    SS_RUN: begin
                        if (tick) begin
                            if (cnt_r == cmp_r) begin
                                state_nxt = SS_HOLD;
                                set_flag  = 1'b1;
                            end else begin
                                cnt_nxt = cnt_r + 16'h0001;
                            end
                        end
                    end
                    SS_HOLD: begin
                        if (tick) begin
                            state_nxt = SS_IDLE;
                        end
                    end
                    default: state_nxt = SS_IDLE;
                endcase
            end
            MODE_PWM: begin
                if (tick) begin
                    if (cnt_r[7:0] == cmp_lo) begin
                        cnt_nxt  = RST_WORD;
                        set_flag = 1'b1;
                    end else begin
                        cnt_nxt = {8'h00, cnt_r[7:0] + 8'h01};
                    end
                end
            end
            default: begin
                if (tick) begin
                    if (cnt_r == cmp_r) begin
                        cnt_nxt  = RST_WORD;
                        set_flag = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r + 16'h0001;
                    end
                end
            end
        endcase
        // Start without event; writing the top value first stops it at once
        if (is_single & enable_rise & ~halted) begin
            state_nxt = SS_RUN;
        end
        if (!enable) begin
            state_nxt = SS_IDLE;
        end
        if (active & restart_en & COMPANION_RESTART) begin
            cnt_nxt = RST_WORD;
        end
    end

    wire running = is_single ? (state_r == SS_RUN) : active;

    // ------------------------------------------------------------
    // Waveform output
    // ------------------------------------------------------------
    logic pin_r;
    logic pin_nxt;

    // High for cmp_hi counts of 0..cmp_lo; cmp_hi = cmp_lo + 1 stays high; cmp_lo = 0 stays low
    wire pwm_high = (cnt_nxt[7:0] < cmp_hi) & (cmp_lo != 8'h00);

    always_comb begin
        if (!out_en) begin
            pin_nxt = 1'b0;
        end else if (is_single) begin
            pin_nxt = (state_nxt == SS_RUN)
                    | (immed_sel & (state_nxt == SS_DELAY));
        end else if (is_pwm) begin
            pin_nxt = enable & pwm_high;
        end else begin
            pin_nxt = init_lvl;
        end
    end

    // With the filter off the immediate path is combinational from the event input, so a glitch
    // on the event line reaches the pin; that is the price of zero latency
    wire immed_now = out_en & immed_sel & hit;
    assign WAVEFORM_PIN = pin_r | immed_now;

    assign IRQ = flag_r & ie_r;

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------
    logic [7:0] rd_byte;

    always_comb begin
        case (idx)
            IDX_CTRL_MAIN: rd_byte = main_r & MASK_CTRL_MAIN;
            IDX_CTRL_MODE: rd_byte = mode_r & MASK_CTRL_MODE;
            IDX_EV_CTRL:   rd_byte = evc_r & MASK_EV_CTRL;
            IDX_INT_EN:    rd_byte = {7'h00, ie_r};
            IDX_INT_FLAG:  rd_byte = {7'h00, flag_r};
            IDX_STATUS:    rd_byte = {7'h00, running};
            IDX_DEBUG:     rd_byte = {7'h00, halt_ovr_r};
            IDX_LATCH:     rd_byte = latch_r;
            default:       rd_byte = 8'h00;
        endcase
    end

    wire [DATA_W-1:0] rd_word = word_sel ? {16'h0000, word_rd} : {24'h000000, rd_byte};

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ack_r   <= 1'b0;
            rdata_r <= '0;
        end else begin
            ack_r <= req_act & ~ack_r;
            if (rd_load) begin
                rdata_r <= rd_word;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            main_r     <= RST_BYTE;
            mode_r     <= RST_BYTE;
            evc_r      <= RST_BYTE;
            ie_r       <= 1'b0;
            halt_ovr_r <= 1'b0;
        end else if (wr_lane0) begin
            if (idx == IDX_CTRL_MAIN) main_r <= wd[7:0] & MASK_CTRL_MAIN;
            if (idx == IDX_CTRL_MODE) mode_r <= wd[7:0] & MASK_CTRL_MODE;
            if (idx == IDX_EV_CTRL)   evc_r  <= wd[7:0] & MASK_EV_CTRL;
            if (idx == IDX_INT_EN)    ie_r   <= wd[FLAG_BIT];
            if (idx == IDX_DEBUG)     halt_ovr_r <= wd[HALT_BIT];
        end
    end

    // Low byte read parks the high byte; low byte write parks data
    wire latch_ld_rd = rd_load & word_sel & lo_only;
    wire latch_ld_wr = wr_do & word_sel & lo_only;
    wire latch_wr    = wr_lane0 & (idx == IDX_LATCH);

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            latch_r <= RST_BYTE;
        end else if (latch_ld_rd) begin
            latch_r <= word_rd[15:8];
        end else if (latch_ld_wr | latch_wr) begin
            latch_r <= wd[7:0];
        end
    end

    // Hardware setting the flag wins over a clear in the same cycle
    wire flag_clr = wr_lane0 & (idx == IDX_INT_FLAG) & wd[FLAG_BIT];

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            flag_r    <= 1'b0;
            EVENT_OUT <= 1'b0;
        end else begin
            flag_r    <= set_flag | (flag_r & ~flag_clr);
            EVENT_OUT <= set_flag;
        end
    end

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cnt_r <= RST_WORD;
            cmp_r <= RST_WORD;
        end else begin
            cnt_r <= cnt_wr ? word_wr(wd, latch_r) : cnt_nxt;
            if (cmp_wr) cmp_r <= word_wr(wd, latch_r);
        end
    end

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_r   <= SS_IDLE;
            en_prev_r <= 1'b0;
            div_r     <= 1'b0;
            pin_r     <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            en_prev_r <= enable;
            div_r     <= ~div_r;
            pin_r     <= pin_nxt;
        end
    end

    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            samp_r     <= '0;
            filt_r     <= 1'b0;
            prev_lvl_r <= 1'b0;
        end else begin
            samp_r     <= {samp_r[FILTER_DEPTH-2:0], EVENT_IN};
            prev_lvl_r <= lvl;
            filt_r     <= filt_lvl;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);

    wire sync_shot = is_single & out_en & ~immed_sel;

    AST_IDLE_LOW: assert property (
        (sync_shot && state_r == SS_IDLE && $past(state_r) == SS_IDLE)
        |-> !WAVEFORM_PIN)
        else $error("pin high while single-shot idle");

    AST_START_CLEAR: assert property (
        (hit && enable && !cnt_wr) |=> (cnt_r == 16'h0000) ##1 (state_r == SS_RUN || !enable))
        else $error("event did not clear and start counter");

    AST_HOLD_IGNORE: assert property (
        (state_r == SS_HOLD) |=> (state_r != SS_DELAY))
        else $error("event accepted during hold");

    AST_SYNC_DELAY: assert property (
        (hit && sync_shot) ##1 (enable && sync_shot)[*2] |->
        !$past(WAVEFORM_PIN) && WAVEFORM_PIN)
        else $error("sync output not high two cycles after event");

    AST_IMMED_NOW: assert property (
        (hit && out_en && immed_sel) |-> WAVEFORM_PIN ##1 (state_r == SS_DELAY || !enable))
        else $error("immediate output not set on event");

    AST_PWM_ZERO: assert property (
        (is_pwm && cmp_lo == 8'h00) |=> !pin_r)
        else $error("pwm output not forced low");

    AST_INIT_LEVEL: assert property (
        (out_en && !is_single && !is_pwm) |=> (pin_r == $past(init_lvl)))
        else $error("initial level not driven");

    AST_IRQ_SET: assert property (
        (set_flag && ie_r && !(wr_lane0 && idx == IDX_INT_EN)) |=> IRQ)
        else $error("interrupt not raised on flag");

    AST_EVENT_OUT: assert property (
        $rose(EVENT_OUT) |-> flag_r)
        else $error("event strobe without flag");

    AST_FILTER: assert property (
        (samp_r == 4'hf) |=> filt_r)
        else $error("filter did not pass stable level");

    AST_HALT_FREEZE: assert property (
        (halted && !cnt_wr && !COMPANION_RESTART) |=> $stable(cnt_r))
        else $error("counter moved while halted");

    COV_SHOT: cover property (hit ##[1:300] (state_r == SS_HOLD));
    COV_PWM: cover property (is_pwm && pin_r ##[1:300] !pin_r);
    COV_IMMED: cover property (immed_now);
    COV_IRQ: cover property ($rose(IRQ));

endmodule

/* File: dv/etp_far_side.sv */
// Far-side model: event routing source that feeds the timer's event input
`timescale 1ns/10ps
module etp_far_side (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic level_req,
    output logic      event_line
);
    // Registered, so every event level lasts one whole clock at least
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            event_line <= 1'b0;
        end else begin
            event_line <= level_req;
        end
    end
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the event timer
`timescale 1ns/10ps
module testbench;
    import etp_pkg::*;
    typedef struct {logic [5:0] a; logic [31:0] wd; logic [31:0] rb;} etp_row_type;
    logic            clk = 1'b0;
    logic            rst_n = 1'b0;
    etp_avs_req_type req = '0;
    logic [31:0]     rdata;
    logic [31:0]     rd;
    logic [31:0]     b;
    logic            wq, pin, ev_out, irq, ev_line;
    logic            deep = 1'b0;
    logic            ctick = 1'b0, crst = 1'b0;
    logic            lvl = 1'b0;
    int              miscompares = 0;
    int              num_checks = 0;
    int              n, w, p, evc;
    etp_row_type     rows[9] = '{'{6'h00, 32'h56, 32'h56}, '{6'h04, 32'hff, 32'h77}, '{6'h10, 32'hff, 32'h51},
        '{6'h14, 32'hff, 32'h01}, '{6'h1c, 32'hff, 32'h00}, '{6'h20, 32'hff, 32'h01},
        '{6'h24, 32'ha5, 32'ha5}, '{6'h30, 32'h1234, 32'h1234}, '{6'h08, 32'hff, 32'h00}};
    logic [15:0]     pcmp[4] = '{16'h0204, 16'h0004, 16'h0504, 16'h0204};
    int              phi[4] = '{4, 0, 10, 4};
    int              dly[3] = '{2, 0, 6};

    always #25 clk = ~clk;
    always @(posedge clk) if (ev_out === 1'b1) evc++;

    etp_event_timer dut (.REF_CLK(clk), .RESET_N(rst_n), .AVS_REQ(req), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wq), .EVENT_IN(ev_line), .COMPANION_TICK(ctick), .COMPANION_RESTART(crst),
        .SLEEP_STANDBY(1'b0), .SLEEP_DEEP(deep), .DEBUG_HALT(1'b0), .WAVEFORM_PIN(pin),
        .EVENT_OUT(ev_out), .IRQ(irq));
    etp_far_side far (.clk(clk), .rst_n(rst_n), .level_req(lvl), .event_line(ev_line));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic conclude();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic bail();
        miscompares++;
        conclude();
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Waitrequest and read data are taken at the rising edge, before that edge updates them
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
        int t;
        t = 0;
        @(posedge clk);
        req <= '{read: !wr, write: wr, address: a, byteenable: be, writedata: d};
        do begin
            @(posedge clk);
            t++;
            if (t > 20) bail();
        end while (wq !== 1'b0);
        rd = rdata;
        req <= '0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf);
    endtask
    task automatic rdc(input string nm, input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        chk(nm, e, rd);
    endtask
    task automatic wait_pin(input logic v, output int c);
        c = 0;
        while (pin !== v) begin
            @(posedge clk);
            #1;
            c++;
            if (c > 60) bail();
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            rdc("reset value", rows[i].a, 32'h0);
            wr(rows[i].a, rows[i].wd);
            rdc("readback", rows[i].a, rows[i].rb);
        end
        bus(1'b1, 6'h28, 32'h34, 4'h1);
        bus(1'b1, 6'h28, 32'h1200, 4'h2);
        rdc("latched counter", 6'h28, 32'h1234);
        wr(6'h00, 0);
        wr(6'h30, 12);
        wr(6'h28, 0);
        wr(6'h14, 1);
        wr(6'h10, 1);
        wr(6'h04, 32'h16);
        wr(6'h00, 1);
        rdc("start at enable", 6'h1c, 1);
        repeat (30) @(posedge clk);
        rdc("stopped", 6'h1c, 0);
        rdc("flag", 6'h18, 1);
        chk("irq set", 1, irq);
        wr(6'h18, 1);
        @(posedge clk);
        chk("irq clear", 0, irq);
        chk("idle pin", 0, pin);
        for (int j = 0; j < 3; j++) begin
            wr(6'h04, j == 1 ? 32'h56 : 32'h16);
            wr(6'h10, j == 2 ? 32'h41 : 32'h01);
            evc = 0;
            @(posedge clk);
            lvl <= 1'b1;
            @(posedge clk);
            #1;
            wait_pin(1'b1, n);
            chk("start delay", dly[j], n);
            wait_pin(1'b0, w);
            chk("shot width", 1, w >= 12 && w <= 16);
            repeat (4) @(posedge clk);
            chk("event strobes", 1, evc);
            lvl <= 1'b0;
            wr(6'h18, 1);
        end
        for (int k = 0; k < 4; k++) begin
            wr(6'h00, 0);
            wr(6'h30, pcmp[k]);
            wr(6'h28, 0);
            wr(6'h04, 32'h17);
            wr(6'h00, k == 3 ? 32'h3 : 32'h1);
            repeat (3) @(posedge clk);
            p = 0;
            repeat (10) begin
                @(posedge clk);
                #1;
                p += (pin === 1'b1);
            end
            chk("pwm high cycles", phi[k], p);
        end
        wr(6'h00, 0);
        wr(6'h04, 32'h30);
        repeat (2) @(posedge clk);
        chk("initial level high", 1, pin);
        wr(6'h04, 32'h10);
        repeat (2) @(posedge clk);
        chk("initial level low", 0, pin);
        wr(6'h30, 32'hffff);
        wr(6'h00, 1);
        @(posedge clk);
        deep <= 1'b1;
        bus(1'b0, 6'h28, 32'h0, 4'hf);
        b = rd;
        repeat (5) @(posedge clk);
        rdc("frozen count", 6'h28, b);
        @(posedge clk);
        deep <= 1'b0;
        repeat (5) @(posedge clk);
        bus(1'b0, 6'h28, 32'h0, 4'hf);
        chk("count resumes", 1, rd !== b);
        wr(6'h00, 32'h15);
        @(posedge clk);
        crst <= 1'b1;
        @(posedge clk);
        crst <= 1'b0;
        ctick <= 1'b1;
        @(posedge clk);
        ctick <= 1'b0;
        rdc("companion tick and restart", 6'h28, 1);
        conclude();
    end
endmodule
